// File: core/cmmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - rate code 0000 disables continuous measurement
// - motion detector idle while continuous mode off
// - periodic measurement start at selected rate
// - rates defined for output bandwidth 00
// - motion raises interrupt when enabled
// - measurement done raises interrupt when enabled
// - x limit unsigned, 4 mG steps
// - y limit unsigned, 4 mG steps
// - z limit at 0DH, unsigned, resets zero
module cmmc_ctrl
	import cmmc_pkg::*;
#(
	parameter logic [31:0] PERIOD_14HZ  = 32'((CMMC_CLK_HZ * CMMC_MHZ_PER_HZ) / CMMC_FREQ_14HZ),
	parameter logic [31:0] PERIOD_5HZ   = 32'((CMMC_CLK_HZ * CMMC_MHZ_PER_HZ) / CMMC_FREQ_5HZ),
	parameter logic [31:0] PERIOD_2P2HZ = 32'((CMMC_CLK_HZ * CMMC_MHZ_PER_HZ) / CMMC_FREQ_2P2HZ),
	parameter logic [31:0] PERIOD_1HZ   = 32'((CMMC_CLK_HZ * CMMC_MHZ_PER_HZ) / CMMC_FREQ_1HZ)
)(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic [2:0]  axis_inhibit,
	input  wire logic        meas_done,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample_x,
	input  wire logic [15:0] sample_y,
	input  wire logic [15:0] sample_z,
	output var  logic        meas_start,
	output var  logic        cm_active,
	output var  logic        motion_detected,
	output var  logic        int_out,
	output var  logic        factory_low_power_sel,
	output var  logic        force_standby
);
	logic [3:0]        repeat_rate_sel;
	logic              motion_irq_enable;
	logic              done_irq_enable;
	logic [7:0]        x_motion_limit;
	logic [7:0]        y_motion_limit;
	logic [7:0]        z_motion_limit;
	logic              rate_valid;
	cmmc_cm_state_type state;
	cmmc_cm_state_type next_state;
	logic [15:0]       sample [CMMC_AXES];
	logic [15:0]       prev_sample [CMMC_AXES];
	logic [7:0]        limit [CMMC_AXES];
	logic [2:0]        exceed;
	logic              have_prev;
	logic              motion_hit;

	cmmc_tick_if tk ();

	assign sample[0] = sample_x;
	assign sample[1] = sample_y;
	assign sample[2] = sample_z;
	assign limit[0]  = x_motion_limit;
	assign limit[1]  = y_motion_limit;
	assign limit[2]  = z_motion_limit;

	// reserved codes are treated like off
	assign rate_valid  = repeat_rate_sel != CMMC_RATE_OFF
		&& repeat_rate_sel <= CMMC_RATE_LAST;
	assign tk.rate_sel = repeat_rate_sel;
	assign tk.run      = rate_valid;

	cmmc_rate_timer #(
		.PERIOD_14HZ  (PERIOD_14HZ),
		.PERIOD_5HZ   (PERIOD_5HZ),
		.PERIOD_2P2HZ (PERIOD_2P2HZ),
		.PERIOD_1HZ   (PERIOD_1HZ)
	) u_timer (
		.core_clk (core_clk),
		.rstn     (rstn),
		.tk       (tk)
	);

	// continuous_mode_interrupt_control
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			repeat_rate_sel       <= CMMC_RESET_VALUE[3:0];
			force_standby         <= 1'b0;
			motion_irq_enable     <= 1'b0;
			done_irq_enable       <= 1'b0;
			factory_low_power_sel <= 1'b0;
		end
		else if (reg_wr && reg_addr == CMMC_ADDR_CTRL2)
		begin
			repeat_rate_sel       <= reg_wdata[CMMC_RATE_LSB +: CMMC_RATE_W];
			force_standby         <= reg_wdata[CMMC_STBY_BIT];
			motion_irq_enable     <= reg_wdata[CMMC_MOTION_EN_BIT];
			done_irq_enable       <= reg_wdata[CMMC_DONE_EN_BIT];
			factory_low_power_sel <= reg_wdata[CMMC_ULP_BIT];
		end
	end

	// motion limits, unsigned 4 mG per step
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			x_motion_limit <= CMMC_RESET_VALUE;
			y_motion_limit <= CMMC_RESET_VALUE;
			z_motion_limit <= CMMC_RESET_VALUE;
		end
		else if (reg_wr)
		begin
			if (reg_addr == CMMC_ADDR_X_LIMIT)
				x_motion_limit <= reg_wdata;
			if (reg_addr == CMMC_ADDR_Y_LIMIT)
				y_motion_limit <= reg_wdata;
			if (reg_addr == CMMC_ADDR_Z_LIMIT)
				z_motion_limit <= reg_wdata;
		end
	end

	// a tick while a measurement is still in flight is dropped
	always_comb
	begin
		next_state = state;
		unique case (state)
			CMMC_CM_OFF:
				if (rate_valid)
					next_state = CMMC_CM_WAIT_TICK;
			CMMC_CM_WAIT_TICK:
				if (!rate_valid)
					next_state = CMMC_CM_OFF;
				else if (tk.tick)
					next_state = CMMC_CM_MEASURING;
			CMMC_CM_MEASURING:
				if (!rate_valid)
					next_state = CMMC_CM_OFF;
				else if (meas_done)
					next_state = CMMC_CM_WAIT_TICK;
			default:
				next_state = CMMC_CM_OFF;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state      <= CMMC_CM_OFF;
			meas_start <= 1'b0;
			cm_active  <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			meas_start <= state == CMMC_CM_WAIT_TICK && rate_valid && tk.tick;
			cm_active  <= rate_valid;
		end
	end

	// per axis change against the previous continuous sample
	genvar i;
	generate
		for (i = 0; i < CMMC_AXES; i++)
		begin : g_axis
			logic [16:0] diff;
			logic [16:0] mag;
			assign diff = 17'($signed(sample[i])) - 17'($signed(prev_sample[i]));
			assign mag  = diff[16] ? 17'(-diff) : diff;
			assign exceed[i] = !axis_inhibit[i]
				&& mag > {7'h00, limit[i], 2'h0};
			always_ff @(posedge core_clk or negedge rstn)
			begin
				if (!rstn)
					prev_sample[i] <= 16'h0000;
				else if (sample_valid && rate_valid)
					prev_sample[i] <= sample[i];
			end
		end
	endgenerate

	assign motion_hit = sample_valid && rate_valid && have_prev && |exceed;

	// first sample after enabling only seeds the reference
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			have_prev <= 1'b0;
		else if (!rate_valid)
			have_prev <= 1'b0;
		else if (sample_valid)
			have_prev <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			motion_detected <= 1'b0;
			int_out         <= 1'b0;
		end
		else
		begin
			motion_detected <= motion_hit;
			int_out         <= (motion_hit && motion_irq_enable)
				|| (meas_done && done_irq_enable);
		end
	end
endmodule : cmmc_ctrl
`default_nettype wire

// File: core/cmmc_rate_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cmmc_rate_timer
	import cmmc_pkg::*;
#(
	parameter logic [31:0] PERIOD_14HZ  = 32'h0,
	parameter logic [31:0] PERIOD_5HZ   = 32'h0,
	parameter logic [31:0] PERIOD_2P2HZ = 32'h0,
	parameter logic [31:0] PERIOD_1HZ   = 32'h0
)(
	input  wire logic  core_clk,
	input  wire logic  rstn,
	cmmc_tick_if.timer tk
);
	logic [31:0] period;
	logic [31:0] count;
	logic [3:0]  last_rate;

	// lower rates halve from 1 Hz per code step
	always_comb
	begin
		unique case (tk.rate_sel)
			CMMC_RATE_14HZ:  period = PERIOD_14HZ;
			CMMC_RATE_5HZ:   period = PERIOD_5HZ;
			CMMC_RATE_2P2HZ: period = PERIOD_2P2HZ;
			default:         period = PERIOD_1HZ << (tk.rate_sel - CMMC_RATE_1HZ);
		endcase
	end

	// periods are fixed, independent of output bandwidth
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count     <= 32'h0;
			tk.tick   <= 1'b0;
			last_rate <= 4'h0;
		end
		else
		begin
			last_rate <= tk.rate_sel;
			if (!tk.run || last_rate != tk.rate_sel)
			begin
				count   <= 32'h0;
				tk.tick <= 1'b0;
			end
			else if (count >= period - 32'h1)
			begin
				count   <= 32'h0;
				tk.tick <= 1'b1;
			end
			else
			begin
				count   <= count + 32'h1;
				tk.tick <= 1'b0;
			end
		end
	end
endmodule : cmmc_rate_timer
`default_nettype wire

// File: pkg/cmmc_pkg.sv
package cmmc_pkg;
	// register offsets on the documented register port
	localparam logic [7:0] CMMC_ADDR_CTRL2    = 8'h0A;
	localparam logic [7:0] CMMC_ADDR_X_LIMIT  = 8'h0B;
	localparam logic [7:0] CMMC_ADDR_Y_LIMIT  = 8'h0C;
	localparam logic [7:0] CMMC_ADDR_Z_LIMIT  = 8'h0D;
	localparam logic [7:0] CMMC_RESET_VALUE   = 8'h00;

	// field positions in continuous_mode_interrupt_control
	localparam int CMMC_RATE_LSB      = 0;
	localparam int CMMC_RATE_W        = 4;
	localparam int CMMC_STBY_BIT      = 4;
	localparam int CMMC_MOTION_EN_BIT = 5;
	localparam int CMMC_DONE_EN_BIT   = 6;
	localparam int CMMC_ULP_BIT       = 7;

	// repeat_rate_sel codes
	localparam logic [3:0] CMMC_RATE_OFF   = 4'h0;
	localparam logic [3:0] CMMC_RATE_14HZ  = 4'h1;
	localparam logic [3:0] CMMC_RATE_5HZ   = 4'h2;
	localparam logic [3:0] CMMC_RATE_2P2HZ = 4'h3;
	localparam logic [3:0] CMMC_RATE_1HZ   = 4'h4;
	localparam logic [3:0] CMMC_RATE_LAST  = 4'hA;

	// repetition rates in millihertz, clock in hertz
	localparam longint CMMC_CLK_HZ      = 25000000;
	localparam longint CMMC_FREQ_14HZ   = 14000;
	localparam longint CMMC_FREQ_5HZ    = 5000;
	localparam longint CMMC_FREQ_2P2HZ  = 2200;
	localparam longint CMMC_FREQ_1HZ    = 1000;
	localparam longint CMMC_MHZ_PER_HZ  = 1000;

	// samples are 1 mG per lsb, limits 4 mG per step
	localparam int CMMC_SAMPLE_W    = 16;
	localparam int CMMC_LIMIT_SHIFT = 2;
	localparam int CMMC_AXES        = 3;

	typedef enum logic [1:0] {
		CMMC_CM_OFF       = 2'b00,
		CMMC_CM_WAIT_TICK = 2'b01,
		CMMC_CM_MEASURING = 2'b10
	} cmmc_cm_state_type;
endpackage : cmmc_pkg

// File: pkg/cmmc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cmmc_tick_if;
	logic [3:0] rate_sel;
	logic       run;
	logic       tick;
	modport ctrl  (output rate_sel, output run, input tick);
	modport timer (input rate_sel, input run, output tick);
endinterface : cmmc_tick_if
`default_nettype wire

// File: tb/cmmc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cmmc_ctrl_sva (
	input wire logic       core_clk,
	input wire logic       rstn,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       meas_done,
	input wire logic       meas_start,
	input wire logic       cm_active,
	input wire logic       motion_detected,
	input wire logic       int_out,
	input wire logic       factory_low_power_sel,
	input wire logic       force_standby
);
	logic [7:0] ctrl;
	logic       wr_ctrl;
	assign wr_ctrl = reg_wr && reg_addr == 8'h0A;
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			ctrl <= 8'h00;
		else if (wr_ctrl)
			ctrl <= reg_wdata;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_off_no_start: assert property (!cm_active && $past(!cm_active) |-> !meas_start)
		else $error("start while off");
	a_off_no_motion: assert property (!cm_active && $past(!cm_active) |-> !motion_detected)
		else $error("motion while off");
	a_mode_follows: assert property (wr_ctrl |=> ##1
		cm_active == ($past(ctrl[3:0]) inside {[4'h1:4'hA]}))
		else $error("mode does not follow rate code");
	a_start_quiet: assert property (wr_ctrl && reg_wdata[3:0] == 4'h1 && !cm_active
		&& !$past(wr_ctrl) |=> !meas_start [*8])
		else $error("start too early");
	a_motion_irq: assert property (motion_detected && $past(ctrl[5]) |-> int_out)
		else $error("motion interrupt missing");
	a_done_irq: assert property (meas_done && ctrl[6] |=> int_out)
		else $error("done interrupt missing");
	a_int_cause: assert property (int_out |-> motion_detected && $past(ctrl[5])
		|| $past(meas_done && ctrl[6]))
		else $error("interrupt without enabled cause");
	a_factory_bits: assert property (force_standby == ctrl[4] && factory_low_power_sel == ctrl[7])
		else $error("factory bits differ");
	c_motion_irq: cover property (motion_detected && ctrl[5]);
	c_done_irq: cover property (meas_done && ctrl[6]);
	c_start: cover property (meas_start);
endmodule : cmmc_ctrl_sva
bind cmmc_ctrl cmmc_ctrl_sva u_sva (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .meas_done(meas_done), .meas_start(meas_start),
	.cm_active(cm_active), .motion_detected(motion_detected), .int_out(int_out),
	.factory_low_power_sel(factory_low_power_sel), .force_standby(force_standby));
`default_nettype wire

// File: tb/cmmc_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// measurement engine: done and samples three cycles after each start
module cmmc_engine_model (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        meas_start,
	input  wire logic [15:0] sv,
	output var  logic        meas_done,
	output var  logic        sample_valid,
	output var  logic [15:0] sample_x,
	output var  logic [15:0] sample_y,
	output var  logic [15:0] sample_z
);
	logic [2:0] dly;
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			dly <= 3'h0;
		else
			dly <= {dly[1:0], meas_start};
	assign meas_done    = dly[2];
	assign sample_valid = dly[2];
	// samples are only meaningful with valid, so show the inverse otherwise
	assign sample_x = dly[2] ? sv : ~sv;
	assign sample_y = sample_x;
	assign sample_z = sample_x;
endmodule : cmmc_engine_model
`default_nettype wire

// File: tb/test_continuous_measure_motion_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_continuous_measure_motion_ctrl;
	logic core_clk = 0, rstn = 0, reg_wr = 0, meas_done, sample_valid, meas_start;
	logic cm_active, motion_detected, int_out, low_pwr, stby;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [2:0]  axis_inhibit = 3'h0;
	logic [15:0] sv = 16'h0000, sx, sy, sz;
	int error_cnt = 0, checks = 0, mot_n = 0, int_n = 0, i;
	always #20 core_clk = ~core_clk;
	always @(negedge core_clk)
	begin
		mot_n += motion_detected;
		int_n += int_out;
	end
	cmmc_engine_model eng (.core_clk(core_clk), .rstn(rstn), .meas_start(meas_start), .sv(sv),
		.meas_done(meas_done), .sample_valid(sample_valid), .sample_x(sx), .sample_y(sy),
		.sample_z(sz));
	cmmc_ctrl #(.PERIOD_14HZ(32'h14), .PERIOD_5HZ(32'h32), .PERIOD_2P2HZ(32'h50),
		.PERIOD_1HZ(32'h64)) uut (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .axis_inhibit(axis_inhibit),
		.meas_done(meas_done), .sample_valid(sample_valid), .sample_x(sx), .sample_y(sy),
		.sample_z(sz), .meas_start(meas_start), .cm_active(cm_active),
		.motion_detected(motion_detected), .int_out(int_out),
		.factory_low_power_sel(low_pwr), .force_standby(stby));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge core_clk);
		reg_wr = 0;
	endtask : wr
	// hand one sample to the engine and let motion and interrupt settle
	task step(input logic [15:0] v);
		int n;
		sv = v;
		n = 0;
		while (!sample_valid && n < 60)
		begin
			@(negedge core_clk);
			n++;
		end
		chk(n < 60, 1);
		repeat (3) @(negedge core_clk);
	endtask : step
	task t_rates;
		for (int c = 0; c <= 10; c++)
		begin
			wr(8'h0A, 8'(c));
			@(negedge core_clk);
			chk(cm_active, c != 0);
		end
	endtask : t_rates
	// first start about one period after the write, then exactly one period apart
	task t_period(input logic [7:0] code, input int per);
		int n;
		wr(8'h0A, 8'h00);
		wr(8'h0A, code);
		n = 0;
		while (!meas_start && n < 3 * per)
		begin
			@(negedge core_clk);
			n++;
		end
		chk(n >= per - 2 && n <= per + 4, 1);
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (!meas_start && n < 3 * per);
		chk(16'(n), 16'(per));
	endtask : t_period
	// limit of 2 steps is 8 mG: a change of 8 is quiet, 9 is motion
	task t_motion(input logic [7:0] a, input logic [2:0] inh);
		int m0, i0;
		axis_inhibit = inh;
		wr(8'h0A, 8'h00);
		wr(a, 8'h02);
		wr(8'h0A, 8'h21);
		step(16'h0064);
		m0 = mot_n;
		step(16'h006C);
		chk(mot_n - m0, 0);
		m0 = mot_n;
		i0 = int_n;
		step(16'h0075);
		chk(mot_n - m0, 1);
		chk(int_n - i0, 1);
	endtask : t_motion
	task t_done;
		int i0;
		wr(8'h0A, 8'h00);
		wr(8'h0A, 8'h41);
		i0 = int_n;
		step(16'h0000);
		chk(int_n - i0, 1);
	endtask : t_done
	// mid-run reset: z limit back to zero, so a 1 mG change is motion
	task t_reset;
		int m0;
		@(negedge core_clk);
		rstn = 0;
		@(negedge core_clk);
		rstn = 1;
		chk({cm_active, meas_start, motion_detected, int_out, low_pwr, stby}, 16'h0000);
		axis_inhibit = 3'h3;
		wr(8'h0A, 8'h21);
		step(16'h0010);
		m0 = mot_n;
		step(16'h0011);
		chk(mot_n - m0, 1);
	endtask : t_reset
	task tally_and_finish;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#200000;
		error_cnt++;
		tally_and_finish;
	end
	initial
	begin
		repeat (3) @(negedge core_clk);
		rstn = 1;
		chk({cm_active, meas_start, motion_detected, int_out, low_pwr, stby}, 0);
		t_rates;
		t_period(8'h01, 20);
		// 1/2 Hz doubles the 1 Hz period of 100
		t_period(8'h05, 200);
		for (i = 0; i < 3; i++)
			t_motion(8'h0B + 8'(i), ~(3'h1 << i));
		t_done;
		t_reset;
		tally_and_finish;
	end
endmodule : test_continuous_measure_motion_ctrl
`default_nettype wire
